// File: ddx_exchange.sv
// Data-set exchange between drive and controller: word stream in and out
`default_nettype none
module ddx_exchange
    import ddx_pkg::*;
#(
    parameter int NSRC = NUM_SEL_SRC
)(
    input  wire logic                     MCLK,
    input  wire logic                     RST_N,
    // Received words from the serial port
    input  wire logic                     RX_VALID,
    input  wire logic [1:0]               RX_SET,
    input  wire logic [WORD_W-1:0]        RX_WORD,
    input  wire logic                     RX_FRAME_START,
    // Transmit request: which set, which word
    input  wire logic                     TX_REQ,
    input  wire logic [1:0]               TX_SET,
    input  wire logic [1:0]               TX_IDX,
    output logic                          TX_VALID,
    output logic [WORD_W-1:0]             TX_WORD,
    // Drive configuration and status
    input  wire logic [1:0]               CMD_SOURCE,
    input  wire logic                     SUPPLY_ON,
    input  wire ddx_pkg::ddx_stat_s       STAT,
    input  wire logic [NSRC-1:0]          SEL_SOURCES,
    input  wire logic [NUM_CFG_STATE*SEL_W-1:0] SEL_CFG,
    input  wire logic [WORD_W-1:0]        ACTUAL_1,
    input  wire logic [WORD_W-1:0]        ACTUAL_2,
    input  wire logic [WORD_W-1:0]        FIELD_CURRENT,
    input  wire logic [WORD_W-1:0]        POWER_ACT,
    input  wire logic [WORD_W-1:0]        TORQUE_ACT,
    // Decoded outputs
    output ddx_pkg::ddx_cmd_s             CMD,
    output logic [WORD_W-1:0]             DRIVE_COMMAND_WORD,
    output logic [WORD_W-1:0]             SPEED_REF_MAIN,
    output logic [WORD_W-1:0]             SPEED_REF_AUX,
    output logic [NUM_DOUT-1:0]           DIGITAL_OUTPUTS_1_TO_5,
    output logic [AOUT_W-1:0]             ANALOG_OUTPUT_1,
    output logic [AOUT_W-1:0]             ANALOG_OUTPUT_2
);
    // ----------------------------------------------------------------
    // Receive word sequencing
    // ----------------------------------------------------------------
    ddx_rx_e rx_pos, next_rx_pos;
    logic [WORD_W-1:0] cmd_word, next_cmd_word;
    logic [WORD_W-1:0] ref_main, next_ref_main;
    logic [WORD_W-1:0] ref_aux, next_ref_aux;
    logic [WORD_W-1:0] dset3_w1, next_dset3_w1;
    logic [WORD_W-1:0] dset3_w2, next_dset3_w2;
    logic [WORD_W-1:0] dset3_w3, next_dset3_w3;

    // Words of each set arrive in fixed order; a frame start restarts the count
    always_comb
    begin
        next_rx_pos = rx_pos;
        next_cmd_word = cmd_word;
        next_ref_main = ref_main;
        next_ref_aux = ref_aux;
        next_dset3_w1 = dset3_w1;
        next_dset3_w2 = dset3_w2;
        next_dset3_w3 = dset3_w3;
        if (RX_VALID)
        begin
            ddx_rx_e pos;
            pos = RX_FRAME_START ? RX_W1 : rx_pos;
            case (pos)
                RX_W1:
                begin
                    next_rx_pos = RX_W2;
                    if (RX_SET == 2'h0)
                        next_cmd_word = RX_WORD;
                    else if (RX_SET == 2'h2)
                        next_dset3_w1 = RX_WORD;
                end
                RX_W2:
                begin
                    next_rx_pos = RX_W3;
                    if (RX_SET == 2'h0)
                        next_ref_main = RX_WORD;
                    else if (RX_SET == 2'h2)
                        next_dset3_w2 = RX_WORD;
                end
                RX_W3:
                begin
                    next_rx_pos = RX_W1;
                    if (RX_SET == 2'h0)
                        next_ref_aux = RX_WORD;
                    else if (RX_SET == 2'h2)
                        next_dset3_w3 = RX_WORD;
                end
                default:
                    next_rx_pos = RX_W1;
            endcase
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            rx_pos <= RX_W1;
            cmd_word <= CMD_RESET_VAL;
            ref_main <= ZERO_WORD;
            ref_aux <= ZERO_WORD;
            dset3_w1 <= ZERO_WORD;
            dset3_w2 <= ZERO_WORD;
            dset3_w3 <= ZERO_WORD;
        end
        else
        begin
            rx_pos <= next_rx_pos;
            cmd_word <= next_cmd_word;
            ref_main <= next_ref_main;
            ref_aux <= next_ref_aux;
            dset3_w1 <= next_dset3_w1;
            dset3_w2 <= next_dset3_w2;
            dset3_w3 <= next_dset3_w3;
        end
    end

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    ddx_cmd_s next_cmd;
    logic reset_prev, next_reset_prev;
    logic bus_src;
    logic [AOUT_W-1:0] next_ao1, next_ao2;
    logic [NUM_DOUT-1:0] next_dout;

    // Clamp to the output range: +-4096 counts is +-10 V, beyond is saturated
    function automatic logic [AOUT_W-1:0] ao_clamp(input logic [WORD_W-1:0] w);
        logic signed [WORD_W-1:0] s;
        s = signed'(w);
        if (s > AOUT_FULL_SCALE)
            ao_clamp = AOUT_W'(AOUT_FULL_SCALE);
        else if (s < -AOUT_FULL_SCALE)
            ao_clamp = AOUT_W'(-AOUT_FULL_SCALE);
        else
            ao_clamp = w[AOUT_W-1:0];
    endfunction

    assign bus_src = (CMD_SOURCE == SRC_BUS);

    always_comb
    begin
        next_cmd = CMD;
        // Force inactive levels (off, no freewheel, no halt, no run) while another source is in charge
        if (bus_src)
        begin
            next_cmd.drive_on = cmd_word[CMD_ON];
            next_cmd.freewheel_n = cmd_word[CMD_FREEWHEEL_N];
            next_cmd.emergency_halt_n = cmd_word[CMD_HALT_N];
            next_cmd.run = cmd_word[CMD_RUN];
        end
        else
        begin
            next_cmd.drive_on = 1'b0;
            next_cmd.freewheel_n = 1'b1;
            next_cmd.emergency_halt_n = 1'b1;
            next_cmd.run = 1'b0;
        end
        next_cmd.fault_reset = cmd_word[CMD_RESET] & ~reset_prev;
        next_cmd.inch_speed_1 = cmd_word[CMD_INCH1];
        next_cmd.inch_speed_2 = cmd_word[CMD_INCH2];
        next_cmd.cfg_cmd_bits = cmd_word[CMD_CFG_HI:CMD_CFG_LO];
        next_reset_prev = cmd_word[CMD_RESET];
        next_dout = dset3_w1[NUM_DOUT-1:0];
        next_ao1 = ao_clamp(dset3_w2);
        next_ao2 = ao_clamp(dset3_w3);
    end

    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            CMD <= '{freewheel_n: 1'b1, emergency_halt_n: 1'b1, default: '0};
            reset_prev <= 1'b0;
            DIGITAL_OUTPUTS_1_TO_5 <= '0;
            ANALOG_OUTPUT_1 <= '0;
            ANALOG_OUTPUT_2 <= '0;
            DRIVE_COMMAND_WORD <= CMD_RESET_VAL;
            SPEED_REF_MAIN <= ZERO_WORD;
            SPEED_REF_AUX <= ZERO_WORD;
        end
        else
        begin
            CMD <= next_cmd;
            reset_prev <= next_reset_prev;
            DIGITAL_OUTPUTS_1_TO_5 <= next_dout;
            ANALOG_OUTPUT_1 <= next_ao1;
            ANALOG_OUTPUT_2 <= next_ao2;
            // Bits 4,5,6,10 stored for readback but steer nothing
            DRIVE_COMMAND_WORD <= cmd_word;
            SPEED_REF_MAIN <= ref_main;
            SPEED_REF_AUX <= ref_aux;
        end
    end

    // ----------------------------------------------------------------
    // Transmit side
    // ----------------------------------------------------------------
    logic [WORD_W-1:0] state_word;
    logic [WORD_W-1:0] next_tx_word;
    logic next_tx_valid;

    ddx_state_compose #(
        .NSRC(NSRC)
    ) u_state (
        .stat        (STAT),
        .supply_on   (SUPPLY_ON),
        .sel_sources (SEL_SOURCES),
        .sel_cfg     (SEL_CFG),
        .word        (state_word)
    );

    always_comb
    begin
        next_tx_valid = TX_REQ;
        next_tx_word = ZERO_WORD;
        if (TX_REQ)
        begin
            case ({TX_SET, TX_IDX})
                4'h4: next_tx_word = state_word;
                4'h5: next_tx_word = ACTUAL_1;
                4'h6: next_tx_word = ACTUAL_2;
                4'hc: next_tx_word = FIELD_CURRENT;
                4'hd: next_tx_word = POWER_ACT;
                4'he: next_tx_word = TORQUE_ACT;
                default: next_tx_word = ZERO_WORD;
            endcase
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            TX_VALID <= 1'b0;
            TX_WORD <= ZERO_WORD;
        end
        else
        begin
            TX_VALID <= next_tx_valid;
            TX_WORD <= next_tx_word;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    a_reset_edge_pulse: assert property (CMD.fault_reset |=> !CMD.fault_reset)
        else $error("fault reset longer than one cycle");
    a_local_no_on: assert property (!bus_src |=> !CMD.drive_on && !CMD.run)
        else $error("drive on while not bus controlled");
    a_cmd_word_rx: assert property (RX_VALID && RX_SET == 2'h0 && RX_FRAME_START
        |=> ##1 DRIVE_COMMAND_WORD == $past(RX_WORD, 2))
        else $error("command word not taken from first word");
    a_bus_on_follow: assert property (bus_src && cmd_word[CMD_ON] |=> CMD.drive_on)
        else $error("on bit not followed");
    a_inch_follow: assert property (##1 CMD.inch_speed_1 == $past(cmd_word[CMD_INCH1]))
        else $error("inch speed one mismatch");
    a_cfg_cmd: assert property (##1 CMD.cfg_cmd_bits == $past(cmd_word[15:11]))
        else $error("configurable command bits mismatch");
    a_dout_route: assert property (##1 DIGITAL_OUTPUTS_1_TO_5 == $past(dset3_w1[4:0]))
        else $error("digital outputs mismatch");
    a_state_bit6: assert property (TX_REQ && TX_SET == 2'h1 && TX_IDX == 2'h0
        |=> TX_VALID && !TX_WORD[6])
        else $error("state bit 6 not zero");
    a_idle_ready: assert property (TX_REQ && TX_SET == 2'h1 && TX_IDX == 2'h0 && SUPPLY_ON
        && !STAT.running && !STAT.fault |=> TX_WORD[0] && TX_WORD[4] && TX_WORD[5]
        && TX_WORD[9])
        else $error("idle ready bits not set");
    a_fixed_power: assert property (TX_REQ && TX_SET == 2'h3 && TX_IDX == 2'h1
        |=> TX_WORD == $past(POWER_ACT))
        else $error("power word mismatch");

    c_fault_reset: cover property (CMD.fault_reset);
    c_state_read: cover property (TX_VALID && TX_WORD[ST_RDY_ON]);
    c_set3_rx: cover property (RX_VALID && RX_SET == 2'h2 ##1 RX_VALID ##1 RX_VALID);
endmodule
`default_nettype wire

// File: ddx_pkg.sv
// Package for the drive data-set exchange block: constants and carriers
//
// Overview of operation
// - Data set one carries command word, primary reference, secondary reference, in order.
// - Command bits 11 to 15 are passed out for configurable use.
// - Bit0 switches on, bit1 low freewheels, bit2 low halts, bit3 runs.
// - Command bits 0 to 3 act only when command source is the bus.
// - Rising bit 7 resets faults; bits 8 and 9 enable inching speeds.
// - Data set two returns state word and two selectable actual values.
// - State bits 11 to 14 come from four separate selectors.
// - State bits 0..3 ready, ready-run, running, fault; bit15 optical link fault.
// - Bits 4,5 low in freewheel/halt; 7 alarm, 8 at ref, 9 remote, 10 speed high.
// - Supply on, drive off, no fault: bits 0,4,5,9 held at one.
// - Data set three word one bits 0..4 drive digital outputs 1..5.
// - Data set three words two and three drive analogue outputs, 4096 counts per 10 V.
// - Data set four returns field current, power, torque.
// - Four data sets of three sixteen-bit words are exchanged.
`default_nettype none
package ddx_pkg;
    localparam int WORD_W = 16;
    localparam int NUM_SETS = 4;
    localparam int WORDS_PER_SET = 3;
    localparam int NUM_SEL_SRC = 16;
    localparam int SEL_W = 4;
    // Command word bit positions
    localparam int CMD_ON = 0;
    localparam int CMD_FREEWHEEL_N = 1;
    localparam int CMD_HALT_N = 2;
    localparam int CMD_RUN = 3;
    localparam int CMD_RESET = 7;
    localparam int CMD_INCH1 = 8;
    localparam int CMD_INCH2 = 9;
    localparam int CMD_CFG_LO = 11;
    localparam int CMD_CFG_HI = 15;
    // State word bit positions
    localparam int ST_RDY_ON = 0;
    localparam int ST_RDY_RUN = 1;
    localparam int ST_RUNNING = 2;
    localparam int ST_FAULT = 3;
    localparam int ST_FREEWHEEL_N = 4;
    localparam int ST_HALT_N = 5;
    localparam int ST_ALARM = 7;
    localparam int ST_AT_REF = 8;
    localparam int ST_REMOTE = 9;
    localparam int ST_OVER_LEVEL = 10;
    localparam int ST_CFG_LO = 11;
    localparam int ST_LINK_FAULT = 15;
    localparam int NUM_CFG_STATE = 4;
    localparam int NUM_DOUT = 5;
    localparam int AOUT_FULL_SCALE = 4096;
    localparam int AOUT_FULL_VOLTS = 10;
    // Sign plus a full 4096 needs fourteen bits; thirteen would wrap +4096 to -4096
    localparam int AOUT_W = 14;
    // Reset values
    localparam logic [15:0] CMD_RESET_VAL = 16'h0006;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    // Command source setting
    localparam logic [1:0] SRC_MACRO = 2'h0;
    localparam logic [1:0] SRC_TERMINALS = 2'h1;
    localparam logic [1:0] SRC_BUS = 2'h2;
    localparam logic [1:0] SRC_KEY = 2'h3;

    typedef struct packed {
        logic drive_on;
        logic freewheel_n;
        logic emergency_halt_n;
        logic run;
        logic fault_reset;
        logic inch_speed_1;
        logic inch_speed_2;
        logic [4:0] cfg_cmd_bits;
    } ddx_cmd_s;

    typedef struct packed {
        logic rdy_on;
        logic ready_for_operation;
        logic running;
        logic fault;
        logic freewheel_n;
        logic emergency_halt_active_n;
        logic alarm;
        logic reference_reached;
        logic remote;
        logic speed_over_level;
        logic optical_link_fault;
    } ddx_stat_s;

    typedef enum logic [2:0] {
        RX_W1 = 3'h1,
        RX_W2 = 3'h2,
        RX_W3 = 3'h4
    } ddx_rx_e;
endpackage
`default_nettype wire

// File: ddx_plc_model.sv
// Controller-side model: sends data sets one and three, fetches sets two and four
`default_nettype none
module ddx_plc_model
    import ddx_pkg::*;
(
    input  wire logic                     MCLK,
    output logic                          RX_VALID,
    output logic [1:0]                    RX_SET,
    output logic [ddx_pkg::WORD_W-1:0]    RX_WORD,
    output logic                          RX_FRAME_START,
    output logic                          TX_REQ,
    output logic [1:0]                    TX_SET,
    output logic [1:0]                    TX_IDX,
    input  wire logic                     TX_VALID,
    input  wire logic [ddx_pkg::WORD_W-1:0] TX_WORD
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        RX_VALID = 1'b0;
        RX_SET = 2'h0;
        RX_WORD = 16'h0000;
        RX_FRAME_START = 1'b0;
        TX_REQ = 1'b0;
        TX_SET = 2'h0;
        TX_IDX = 2'h0;
    end

    // ---------------------------------------------------------------
    // One whole set, three words back to back, first word framed
    // ---------------------------------------------------------------
    task automatic send_set(input logic [1:0] set, input logic [15:0] w1, w2, w3);
        logic [15:0] w [3];
        begin
            w = '{w1, w2, w3};
            for (int i = 0; i < WORDS_PER_SET; i++)
            begin
                @(negedge MCLK);
                RX_VALID = 1'b1;
                RX_SET = set;
                RX_WORD = w[i];
                RX_FRAME_START = (i == 0);
            end
            @(negedge MCLK);
            RX_VALID = 1'b0;
            RX_FRAME_START = 1'b0;
            // Released data must not look like a held word
            RX_WORD = ~RX_WORD;
        end
    endtask

    // ---------------------------------------------------------------
    // Word fetch; the answer stands for one cycle only
    // ---------------------------------------------------------------
    task automatic read_word(input logic [1:0] set, input logic [1:0] idx,
                             output logic vld, output logic [15:0] word);
        @(negedge MCLK);
        TX_REQ = 1'b1;
        TX_SET = set;
        TX_IDX = idx;
        // The answer stands only between the two edges after the request
        @(negedge MCLK);
        vld = TX_VALID;
        word = TX_WORD;
        TX_REQ = 1'b0;
        TX_SET = ~set;
        TX_IDX = ~idx;
    endtask
endmodule
`default_nettype wire

// File: ddx_state_compose.sv
// Combines drive status signals into the sixteen-bit state word
`default_nettype none
module ddx_state_compose
    import ddx_pkg::*;
#(
    parameter int NSRC = NUM_SEL_SRC
)(
    input  wire ddx_pkg::ddx_stat_s       stat,
    input  wire logic                     supply_on,
    input  wire logic [NSRC-1:0]          sel_sources,
    input  wire logic [NUM_CFG_STATE*SEL_W-1:0] sel_cfg,
    output logic [WORD_W-1:0]             word
);
    logic idle_ok;
    logic [NUM_CFG_STATE-1:0] cfg_bits;

    // Idle-ready bits forced high when supplied, off and healthy
    assign idle_ok = supply_on && !stat.running && !stat.fault;

    genvar g;
    generate
        for (g = 0; g < NUM_CFG_STATE; g++)
        begin : g_sel
            assign cfg_bits[g] = sel_sources[sel_cfg[g*SEL_W +: SEL_W]];
        end
    endgenerate

    always_comb
    begin
        word = ZERO_WORD;
        word[ST_RDY_ON] = stat.rdy_on | idle_ok;
        word[ST_RDY_RUN] = stat.ready_for_operation;
        word[ST_RUNNING] = stat.running;
        word[ST_FAULT] = stat.fault;
        word[ST_FREEWHEEL_N] = stat.freewheel_n | idle_ok;
        word[ST_HALT_N] = stat.emergency_halt_active_n | idle_ok;
        word[ST_ALARM] = stat.alarm;
        word[ST_AT_REF] = stat.reference_reached;
        word[ST_REMOTE] = stat.remote | idle_ok;
        word[ST_OVER_LEVEL] = stat.speed_over_level;
        word[ST_CFG_LO +: NUM_CFG_STATE] = cfg_bits;
        word[ST_LINK_FAULT] = stat.optical_link_fault;
    end
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking bench for the data-set exchange block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ddx_pkg::*;

    logic              mclk = 1'b0;
    logic              rst_n = 1'b0;
    logic              rx_valid, rx_frame_start, tx_req, tx_valid, supply_on, vld;
    logic [1:0]        rx_set, tx_set, tx_idx, cmd_source, st, ix;
    logic [15:0]       rx_word, tx_word, sel_sources, sel_cfg, act1, act2, fld, pwr, trq;
    logic [15:0]       cmd_word, ref_main, ref_aux, w, r1, r2, got, prev_w;
    logic [4:0]        dout;
    logic [13:0]       aout1, aout2;
    logic [31:0]       refs;
    int                n_pulse = 0;
    int                p0;
    ddx_stat_s         stat;
    ddx_cmd_s          cmd;
    int                n_mismatch = 0;
    int                n_tests = 0;
    logic [15:0]       cmd_corner [4] = '{16'h0006, 16'h0000, 16'hffff, 16'h0786};
    logic [15:0]       ao_corner [6] = '{16'h0fff, 16'hf000, 16'h8ad0, 16'h0000,
                                         16'h7fff, 16'h1000};

    always #50 mclk = ~mclk;

    // Fault reset is a one-cycle pulse; count them rather than catch the cycle
    always @(posedge mclk)
    begin
        if (cmd.fault_reset)
            n_pulse <= n_pulse + 1;
    end

    ddx_plc_model plc (.MCLK(mclk), .RX_VALID(rx_valid), .RX_SET(rx_set), .RX_WORD(rx_word),
        .RX_FRAME_START(rx_frame_start), .TX_REQ(tx_req), .TX_SET(tx_set), .TX_IDX(tx_idx),
        .TX_VALID(tx_valid), .TX_WORD(tx_word));

    ddx_exchange DUT (.MCLK(mclk), .RST_N(rst_n), .RX_VALID(rx_valid), .RX_SET(rx_set),
        .RX_WORD(rx_word), .RX_FRAME_START(rx_frame_start), .TX_REQ(tx_req), .TX_SET(tx_set),
        .TX_IDX(tx_idx), .TX_VALID(tx_valid), .TX_WORD(tx_word), .CMD_SOURCE(cmd_source),
        .SUPPLY_ON(supply_on), .STAT(stat), .SEL_SOURCES(sel_sources), .SEL_CFG(sel_cfg),
        .ACTUAL_1(act1), .ACTUAL_2(act2), .FIELD_CURRENT(fld), .POWER_ACT(pwr),
        .TORQUE_ACT(trq), .CMD(cmd), .DRIVE_COMMAND_WORD(cmd_word), .SPEED_REF_MAIN(ref_main),
        .SPEED_REF_AUX(ref_aux), .DIGITAL_OUTPUTS_1_TO_5(dout), .ANALOG_OUTPUT_1(aout1),
        .ANALOG_OUTPUT_2(aout2));

    // ---------------------------------------------------------------
    // Comparison, expectations and verdict
    // ---------------------------------------------------------------
    task automatic check(input logic [63:0] g, input logic [63:0] e);
        n_tests++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic stop_test();
        $display("Mismatches %0d of %0d checks", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    function automatic ddx_cmd_s exp_cmd(input logic [15:0] c, input logic [1:0] src,
                                         input logic pulse);
        ddx_cmd_s e;
        logic bus;
        bus = (src == 2'h2);
        e.drive_on = bus & c[0];
        e.freewheel_n = ~bus | c[1];
        e.emergency_halt_n = ~bus | c[2];
        e.run = bus & c[3];
        e.fault_reset = pulse;
        e.inch_speed_1 = c[8];
        e.inch_speed_2 = c[9];
        e.cfg_cmd_bits = c[15:11];
        return e;
    endfunction

    function automatic logic [15:0] exp_state();
        logic ok;
        logic [15:0] s;
        ok = supply_on & ~stat.running & ~stat.fault;
        s = {stat.optical_link_fault, 4'h0, stat.speed_over_level, stat.remote | ok,
             stat.reference_reached, stat.alarm, 1'b0, stat.emergency_halt_active_n | ok,
             stat.freewheel_n | ok, stat.fault, stat.running, stat.ready_for_operation,
             stat.rdy_on | ok};
        for (int i = 0; i < 4; i++)
            s[11 + i] = sel_sources[sel_cfg[i * 4 +: 4]];
        return s;
    endfunction

    function automatic logic [15:0] exp_tx(input logic [1:0] s, input logic [1:0] i);
        case ({s, i})
            4'h4: return exp_state();
            4'h5: return act1;
            4'h6: return act2;
            4'hc: return fld;
            4'hd: return pwr;
            4'he: return trq;
            default: return 16'h0000;
        endcase
    endfunction

    function automatic logic [13:0] exp_ao(input logic [15:0] a);
        // Beyond full scale either way the output pins at +-4096
        if ($signed(a) > 4096)
            return 14'h1000;
        if ($signed(a) < -4096)
            return 14'h3000;
        return a[13:0];
    endfunction

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h74a3c362));
        {cmd_source, supply_on, stat, sel_sources, sel_cfg} = '0;
        {act1, act2, fld, pwr, trq} = '0;
        cmd_source = SRC_BUS;
        repeat (20) @(negedge mclk);
        rst_n = 1'b1;
        check(cmd_word, CMD_RESET_VAL);
        check(cmd, exp_cmd(CMD_RESET_VAL, SRC_BUS, 1'b0));
        check({dout, aout1, aout2}, 64'h0);
        check({ref_main, ref_aux}, 64'h0);
        check(tx_valid, 1'b0);
        prev_w = CMD_RESET_VAL;
        // Data set one under every command source
        for (int k = 0; k < 24; k++)
        begin
            cmd_source = k[1:0];
            // Random words keep freewheel and halt inactive, as a controller must
            w = (k < 4) ? cmd_corner[k] : (16'($urandom) | 16'h0006);
            r1 = 16'($urandom);
            r2 = 16'($urandom);
            p0 = n_pulse;
            plc.send_set(2'h0, w, r1, r2);
            check(cmd_word, w);
            check(cmd, exp_cmd(w, cmd_source, 1'b0));
            repeat (2) @(negedge mclk);
            check(n_pulse - p0, w[7] & ~prev_w[7]);
            check(cmd, exp_cmd(w, cmd_source, 1'b0));
            check({ref_main, ref_aux}, {r1, r2});
            refs = {r1, r2};
            prev_w = w;
        end
        // Data set three, then sets that travel the other way are ignored
        for (int k = 0; k < 10; k++)
        begin
            w = 16'($urandom);
            r1 = (k < 6) ? ao_corner[k] : 16'($urandom_range(8191) - 4096);
            r2 = (k < 6) ? ao_corner[5 - k] : 16'($urandom_range(8191) - 4096);
            plc.send_set(2'h2, w, r1, r2);
            repeat (2) @(negedge mclk);
            check(dout, w[4:0]);
            check({aout1, aout2}, {exp_ao(r1), exp_ao(r2)});
        end
        plc.send_set(2'h1, 16'hfff0, 16'h1234, 16'h4321);
        plc.send_set(2'h3, 16'hffe0, 16'h0100, 16'hff00);
        repeat (2) @(negedge mclk);
        check({cmd_word, dout}, {prev_w, w[4:0]});
        check({ref_main, ref_aux, aout1, aout2}, {refs, exp_ao(r1), exp_ao(r2)});
        // Data sets two and four, plus invalid set and word numbers
        for (int k = 0; k < 48; k++)
        begin
            stat = (k == 0) ? ddx_stat_s'(11'h000) : ddx_stat_s'(11'($urandom));
            supply_on = (k == 0) ? 1'b1 : 1'($urandom);
            {sel_sources, sel_cfg} = $urandom;
            {act1, act2} = $urandom;
            {fld, pwr} = $urandom;
            trq = 16'($urandom);
            st = (k < 8) ? 2'h1 : 2'($urandom);
            ix = (k < 8) ? 2'(k % 3) : 2'($urandom);
            plc.read_word(st, ix, vld, got);
            check(vld, 1'b1);
            check(got, exp_tx(st, ix));
            @(negedge mclk);
            check(tx_valid, 1'b0);
        end
        stop_test();
    end
endmodule
`default_nettype wire
